// >>> logic/aogt_regs.svh
// Register indices, field layouts and reset values of the trim bank.
// Assumes 32-bit Avalon-MM data with one aligned word per register.
// How it works
// R01: Software keeps the reserved upper bits of every trim register at zero.
// R02: The converter 3 input D offset field drives converter 3 on input D.
// R03: The converter 4 and 5 offset fields drive their own converters.
// R04: The converter 0 and 1 gain fields drive those converters.
// R05: Converter 2 takes the input A gain or the input B gain by its input.
// R06: Converter 3 takes its input C gain field while it samples input C.
// R07: After reset every trim field is filled with its factory fuse value.
// R08: Every offset field is handed on as an unsigned number.
// R09: Software leaves the offset registers alone during offset calibration.
// R10: A read returns the whole stored value, reserved bits included.
`ifndef AOGT_REGS_SVH
`define AOGT_REGS_SVH

// Register indices; the byte address is four times the index
`define AOGT_IDX_OFS_ADC3D 10'h33A
`define AOGT_IDX_OFS_ADC4  10'h33C
`define AOGT_IDX_OFS_ADC5  10'h33E
`define AOGT_IDX_GAIN_ADC0 10'h360
`define AOGT_IDX_GAIN_ADC1 10'h361
`define AOGT_IDX_GAIN_A2A  10'h362
`define AOGT_IDX_GAIN_A2B  10'h363
`define AOGT_IDX_GAIN_A3C  10'h364

// Storage slots, also the fuse word addresses
`define AOGT_SLOT_OFF3D 3'h0
`define AOGT_SLOT_OFF4  3'h1
`define AOGT_SLOT_OFF5  3'h2
`define AOGT_SLOT_GN0   3'h3
`define AOGT_SLOT_GN1   3'h4
`define AOGT_SLOT_GN2A  3'h5
`define AOGT_SLOT_GN2B  3'h6
`define AOGT_SLOT_GN3C  3'h7
`define AOGT_SLOT_LAST  3'h7
`define AOGT_NUM_SLOTS  8

// Field layouts
`define AOGT_OFS_MSB   11
`define AOGT_GAIN_MSB  4
`define AOGT_OFS_FIELD  16'h0FFF
`define AOGT_GAIN_FIELD 16'h001F
`define AOGT_OFS_WIDTH  16'hFFFF
`define AOGT_GAIN_WIDTH 16'h00FF

// Reset values
`define AOGT_TRIM_RESET 16'h0000
`define AOGT_READ_ZERO  32'h0000_0000

`endif

// >>> logic/aogt_pkg.sv
// Types shared by the trim register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package aogt_pkg;

	// Fuse default load sequencer
	typedef enum logic [0:0] {
		AOGT_LOAD,
		AOGT_READY
	} aogt_load_state_t;

	typedef logic [15:0] aogt_trim_t;

endpackage

// >>> logic/aogt_trim_regs.sv
// Offset and fine gain trim bank with its fuse default loader.
// Assumes an Avalon-MM master on clk_sys and a fuse reader that answers
// each word request with one-cycle fuse_rd_valid on the same clock.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`include "aogt_regs.svh"

module aogt_trim_regs (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Avalon-MM slave, byte address
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Fuse default reader
	output logic             fuse_rd_req,
	output logic      [2:0]  fuse_rd_addr,
	input  wire logic [15:0] fuse_rd_data,
	input  wire logic        fuse_rd_valid,
	// Active input of the converters
	input  wire logic        adc2_input_b_sel,
	input  wire logic        adc3_input_d_sel,
	// Trim values to the converters
	output logic      [4:0]  adc0_gain,
	output logic      [4:0]  adc1_gain,
	output logic      [4:0]  adc2_gain,
	output logic      [4:0]  adc3_gain,
	output logic             adc3_gain_vld,
	output logic      [11:0] adc3_offset,
	output logic             adc3_offset_vld,
	output logic      [11:0] adc4_offset,
	output logic      [11:0] adc5_offset,
	output logic             trim_ready
);

	aogt_pkg::aogt_load_state_t load_state_reg;
	aogt_pkg::aogt_trim_t       trim_reg [`AOGT_NUM_SLOTS];

	logic [9:0]  bus_index;
	logic [3:0]  bus_decode;
	logic        bus_hit;
	logic [2:0]  bus_slot;
	logic        bus_req;
	logic        wr_accept;
	logic        rd_accept;
	logic [15:0] rd_value;

	// Index decode shared by the read and write paths
	function automatic logic [3:0] aogt_decode(input logic [9:0] index);
		logic [3:0] res;
		res = 4'h0;
		case (index)
			`AOGT_IDX_OFS_ADC3D: res = {1'b1, `AOGT_SLOT_OFF3D};
			`AOGT_IDX_OFS_ADC4:  res = {1'b1, `AOGT_SLOT_OFF4};
			`AOGT_IDX_OFS_ADC5:  res = {1'b1, `AOGT_SLOT_OFF5};
			`AOGT_IDX_GAIN_ADC0: res = {1'b1, `AOGT_SLOT_GN0};
			`AOGT_IDX_GAIN_ADC1: res = {1'b1, `AOGT_SLOT_GN1};
			`AOGT_IDX_GAIN_A2A:  res = {1'b1, `AOGT_SLOT_GN2A};
			`AOGT_IDX_GAIN_A2B:  res = {1'b1, `AOGT_SLOT_GN2B};
			`AOGT_IDX_GAIN_A3C:  res = {1'b1, `AOGT_SLOT_GN3C};
			default:             res = 4'h0;
		endcase
		return res;
	endfunction

	// Gains are one byte wide, offsets two
	function automatic logic [15:0] aogt_width(input logic [2:0] slot);
		logic [15:0] res;
		res = `AOGT_OFS_WIDTH;
		if (slot >= `AOGT_SLOT_GN0) begin
			res = `AOGT_GAIN_WIDTH;
		end
		return res;
	endfunction

	// Trim field only, so fuse data never lands in reserved bits
	function automatic logic [15:0] aogt_field(input logic [2:0] slot);
		logic [15:0] res;
		res = `AOGT_OFS_FIELD;
		if (slot >= `AOGT_SLOT_GN0) begin
			res = `AOGT_GAIN_FIELD;
		end
		return res;
	endfunction

	assign bus_index = avs_address[11:2];
	// Decoded once so read and write always agree on the slot
	assign bus_decode = aogt_decode(bus_index);
	assign bus_hit   = bus_decode[3];
	assign bus_slot  = bus_decode[2:0];
	assign bus_req   = avs_read | avs_write;
	assign wr_accept = avs_write & ~avs_waitrequest;
	assign rd_accept = avs_read & ~avs_waitrequest;
	assign rd_value  = trim_reg[bus_slot] & aogt_width(bus_slot);

	// Fuse default loader
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			load_state_reg <= aogt_pkg::AOGT_LOAD;
			fuse_rd_req    <= 1'b1;
			fuse_rd_addr   <= `AOGT_SLOT_OFF3D;
			trim_ready     <= 1'b0;
		end else begin
			case (load_state_reg)
				aogt_pkg::AOGT_LOAD: begin
					if (fuse_rd_valid) begin // [R07]
						if (fuse_rd_addr == `AOGT_SLOT_LAST) begin
							load_state_reg <= aogt_pkg::AOGT_READY;
							fuse_rd_req    <= 1'b0;
							trim_ready     <= 1'b1;
						end else begin
							fuse_rd_addr <= fuse_rd_addr + 3'h1;
						end
					end
				end
				aogt_pkg::AOGT_READY: begin
					fuse_rd_req <= 1'b0;
					trim_ready  <= 1'b1;
				end
				default: begin
					load_state_reg <= aogt_pkg::AOGT_LOAD;
					fuse_rd_req    <= 1'b1;
					fuse_rd_addr   <= `AOGT_SLOT_OFF3D;
					trim_ready     <= 1'b0;
				end
			endcase
		end
	end

	// One wait cycle per access; the bus stalls until the defaults are in
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest & trim_ready);
		end
	end

	// Read data stands at the accept edge; unmapped reads return zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= `AOGT_READ_ZERO;
		end else if (avs_read && avs_waitrequest && trim_ready) begin
			if (bus_hit) begin
				avs_readdata <= {16'h0000, rd_value}; // [R10]
			end else begin
				avs_readdata <= `AOGT_READ_ZERO;
			end
		end
	end

	// Trim storage: bus writes keep bits 15:0 of offsets and bits 7:0 of gains, reserved ones too
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `AOGT_NUM_SLOTS; i++) begin
				trim_reg[i] <= `AOGT_TRIM_RESET;
			end
		end else begin
			for (int i = 0; i < `AOGT_NUM_SLOTS; i++) begin
				if (wr_accept && bus_hit && bus_slot == 3'(i)) begin
					if (avs_byteenable[0]) begin
						trim_reg[i][7:0] <= avs_writedata[7:0]; // [R10]
					end
					if (avs_byteenable[1] && 3'(i) < `AOGT_SLOT_GN0) begin
						trim_reg[i][15:8] <= avs_writedata[15:8]; // [R10]
					end
				end else if (load_state_reg == aogt_pkg::AOGT_LOAD &&
					fuse_rd_valid && fuse_rd_addr == 3'(i)) begin
					trim_reg[i] <= fuse_rd_data & aogt_field(3'(i)); // [R07]
				end
			end
		end
	end

	// Offsets to the converters, unsigned and unmodified
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			adc3_offset     <= 12'h000;
			adc3_offset_vld <= 1'b0;
			adc4_offset     <= 12'h000;
			adc5_offset     <= 12'h000;
		end else begin
			adc3_offset <= // [R02] [R08]
				trim_reg[`AOGT_SLOT_OFF3D][`AOGT_OFS_MSB:0];
			adc3_offset_vld <= adc3_input_d_sel & trim_ready; // [R02]
			adc4_offset <= // [R03] [R08]
				trim_reg[`AOGT_SLOT_OFF4][`AOGT_OFS_MSB:0];
			adc5_offset <= // [R03] [R08]
				trim_reg[`AOGT_SLOT_OFF5][`AOGT_OFS_MSB:0];
		end
	end

	// Gains to the converters
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			adc0_gain     <= 5'h00;
			adc1_gain     <= 5'h00;
			adc2_gain     <= 5'h00;
			adc3_gain     <= 5'h00;
			adc3_gain_vld <= 1'b0;
		end else begin
			adc0_gain <= trim_reg[`AOGT_SLOT_GN0][`AOGT_GAIN_MSB:0]; // [R04]
			adc1_gain <= trim_reg[`AOGT_SLOT_GN1][`AOGT_GAIN_MSB:0]; // [R04]
			if (adc2_input_b_sel) begin
				adc2_gain <= trim_reg[`AOGT_SLOT_GN2B][`AOGT_GAIN_MSB:0]; // [R05]
			end else begin
				adc2_gain <= trim_reg[`AOGT_SLOT_GN2A][`AOGT_GAIN_MSB:0]; // [R05]
			end
			// Input C is simply the converter 3 input that is not D
			adc3_gain     <= trim_reg[`AOGT_SLOT_GN3C][`AOGT_GAIN_MSB:0]; // [R06]
			adc3_gain_vld <= ~adc3_input_d_sel & trim_ready; // [R06]
		end
	end

	// Checks
	sequence fuse_word_s;
		load_state_reg == aogt_pkg::AOGT_LOAD && fuse_rd_valid;
	endsequence

	sequence bus_write_full_s;
		wr_accept && bus_hit && avs_byteenable[1:0] == 2'h3;
	endsequence

	sequence bus_write_low_s;
		wr_accept && bus_hit && avs_byteenable[1:0] == 2'h1;
	endsequence

	sequence bus_read_wait_s;
		avs_read && avs_waitrequest && trim_ready ##1 avs_read;
	endsequence

	property fuse_fill_p;
		@(posedge clk_sys) disable iff (!rst_n)
		fuse_word_s |=>
			trim_reg[$past(fuse_rd_addr)] ==
			($past(fuse_rd_data) & aogt_field($past(fuse_rd_addr)));
	endproperty

	property write_keep_p;
		@(posedge clk_sys) disable iff (!rst_n)
		bus_write_full_s |=>
			trim_reg[$past(bus_slot)] ==
			($past(avs_writedata[15:0]) & aogt_width($past(bus_slot)));
	endproperty

	property read_back_p;
		@(posedge clk_sys) disable iff (!rst_n)
		bus_read_wait_s |->
			!avs_waitrequest &&
			avs_readdata == (bus_hit ? {16'h0000, $past(rd_value)} :
				`AOGT_READ_ZERO);
	endproperty

	fuse_default_fill_a: assert property (fuse_fill_p) // [R07]
		else $error("fuse word not stored in its trim field");

	load_ends_ready_a: assert property ( // [R07]
		@(posedge clk_sys) disable iff (!rst_n)
		fuse_word_s ##0 fuse_rd_addr == `AOGT_SLOT_LAST |=>
			trim_ready && !fuse_rd_req [*2])
		else $error("loader did not finish after last fuse word");

	load_req_done_a: assert property ( // [R07]
		@(posedge clk_sys) disable iff (!rst_n)
		trim_ready |-> !fuse_rd_req)
		else $error("fuse request still raised after load");

	fuse_reserved_zero_a: assert property ( // [R07]
		@(posedge clk_sys) disable iff (!rst_n)
		fuse_word_s |=>
			(trim_reg[$past(fuse_rd_addr)] &
				~aogt_field($past(fuse_rd_addr))) == 16'h0000)
		else $error("fuse load set a reserved bit");

	bus_stall_load_a: assert property ( // [R07]
		@(posedge clk_sys) disable iff (!rst_n)
		!trim_ready |-> avs_waitrequest)
		else $error("bus answered before defaults were loaded");

	// Converter 3 must never mark a half-loaded trim set valid; the other trim outputs have no valid
	vld_hold_load_a: assert property ( // [R07]
		@(posedge clk_sys) disable iff (!rst_n)
		!trim_ready |=> !adc3_offset_vld && !adc3_gain_vld)
		else $error("trim marked valid before defaults were loaded");

	write_readback_a: assert property (write_keep_p) // [R10]
		else $error("written value not held in full");

	write_low_byte_a: assert property ( // [R10]
		@(posedge clk_sys) disable iff (!rst_n)
		bus_write_low_s |=>
			trim_reg[$past(bus_slot)] ==
			{$past(trim_reg[bus_slot][15:8]), $past(avs_writedata[7:0])})
		else $error("byte write disturbed the other byte");

	read_value_a: assert property (read_back_p) // [R10]
		else $error("read data differs from stored value");

	offset3d_apply_a: assert property ( // [R02]
		@(posedge clk_sys) disable iff (!rst_n)
		trim_ready && adc3_input_d_sel |=>
			adc3_offset_vld &&
			adc3_offset == $past(trim_reg[`AOGT_SLOT_OFF3D][11:0]))
		else $error("input D offset not applied to converter 3");

	ofs45_apply_a: assert property ( // [R03]
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=>
			{4'h0, adc4_offset} == ($past(trim_reg[`AOGT_SLOT_OFF4]) &
				`AOGT_OFS_FIELD) &&
			{4'h0, adc5_offset} == ($past(trim_reg[`AOGT_SLOT_OFF5]) &
				`AOGT_OFS_FIELD))
		else $error("converter 4 or 5 offset not applied");

	offset_unsigned_a: assert property ( // [R08]
		@(posedge clk_sys) disable iff (!rst_n)
		$changed(trim_reg[`AOGT_SLOT_OFF4]) |=>
			adc4_offset == $past(trim_reg[`AOGT_SLOT_OFF4][11:0]))
		else $error("offset field altered on its way out");

	gain01_apply_a: assert property ( // [R04]
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=>
			adc0_gain == $past(trim_reg[`AOGT_SLOT_GN0][4:0]) &&
			adc1_gain == $past(trim_reg[`AOGT_SLOT_GN1][4:0]))
		else $error("converter 0 or 1 gain not applied");

	gain2_select_a: assert property ( // [R05]
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=>
			adc2_gain == ($past(adc2_input_b_sel) ?
				$past(trim_reg[`AOGT_SLOT_GN2B][4:0]) :
				$past(trim_reg[`AOGT_SLOT_GN2A][4:0])))
		else $error("converter 2 gain from wrong input register");

	fine_gain_trim_adc3_input_c_apply_a: assert property ( // [R06]
		@(posedge clk_sys) disable iff (!rst_n)
		trim_ready && !adc3_input_d_sel |=>
			adc3_gain_vld && !adc3_offset_vld &&
			adc3_gain == $past(trim_reg[`AOGT_SLOT_GN3C][4:0]))
		else $error("input C gain not applied to converter 3");

	wait_one_cycle_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		bus_req && avs_waitrequest && trim_ready |=>
			!avs_waitrequest ##1 avs_waitrequest)
		else $error("access not answered after one wait cycle");

endmodule

// >>> tb/aogt_trim_regs_tb.sv
// Self-checking bench for the offset and fine gain trim bank.
// Assumes the bank, its header and package under logic/, one 125 MHz clock.
`timescale 1ns/100ps

module aogt_trim_regs_tb;
	logic        clk_sys;
	logic        rst_n;
	logic [11:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        fuse_rd_req;
	logic [2:0]  fuse_rd_addr;
	logic [15:0] fuse_rd_data = 16'h0000;
	logic        fuse_rd_valid = 1'b0;
	logic        adc2_input_b_sel;
	logic        adc3_input_d_sel;
	logic [4:0]  adc0_gain, adc1_gain, adc2_gain, adc3_gain;
	logic        adc3_gain_vld, adc3_offset_vld, trim_ready;
	logic [11:0] adc3_offset, adc4_offset, adc5_offset;
	int          err_count;
	int          tests_run;
	logic [31:0] rd;
	logic [15:0] regv [8];
	logic [9:0]  idx  [8] = '{10'h33A, 10'h33C, 10'h33E, 10'h360,
		10'h361, 10'h362, 10'h363, 10'h364};
	// Fuse words carry junk above each field; only the field may land
	logic [15:0] fuse [8] = '{16'hF123, 16'hE456, 16'hDFFF, 16'hABE3,
		16'h12F4, 16'h34E5, 16'h56F6, 16'h78E7};
	logic [15:0] wv   [8] = '{16'h0ABC, 16'h0701, 16'h0800, 16'h001F,
		16'h000B, 16'h001E, 16'h0001, 16'h0010};

	aogt_trim_regs i_dut (
		.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.fuse_rd_req, .fuse_rd_addr, .fuse_rd_data, .fuse_rd_valid,
		.adc2_input_b_sel, .adc3_input_d_sel, .adc0_gain, .adc1_gain,
		.adc2_gain, .adc3_gain, .adc3_gain_vld, .adc3_offset,
		.adc3_offset_vld, .adc4_offset, .adc5_offset, .trim_ready
	);

	initial clk_sys = 1'b0;
	always #4 clk_sys = ~clk_sys;

	// Fuse reader answers every other cycle; idle data keeps toggling
	always @(posedge clk_sys) begin
		fuse_rd_valid <= fuse_rd_req && !fuse_rd_valid;
		fuse_rd_data  <= (fuse_rd_req && !fuse_rd_valid) ?
			fuse[fuse_rd_addr] : ~fuse_rd_data;
	end

	task automatic end_of_test;
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Called just after a rising edge; leaves one idle edge behind
	task automatic bus(input logic wr, input logic [9:0] ix,
		input logic [31:0] wd, input logic [3:0] be,
		output logic [31:0] rdata);
		int n;
		n = 0;
		avs_address    <= {ix, 2'b00};
		avs_read       <= !wr;
		avs_write      <= wr;
		avs_writedata  <= wd;
		avs_byteenable <= be;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 300);
		rdata = avs_readdata;
		if (n >= 300)
			chk("bus_answer", 32'h0, 32'h1);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask

	// No calibration runs here, so offset access is always free
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			regv[i] = fuse[i] & (i < 3 ? 16'h0FFF : 16'h001F);
	endtask

	task automatic read_all;
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, idx[i], 32'h0, 4'hF, rd);
			chk("readback", rd, {16'h0000, regv[i]});
		end
	endtask

	task automatic chk_outs;
		chk("adc0_gain", 32'(adc0_gain), 32'(regv[3][4:0]));
		chk("adc1_gain", 32'(adc1_gain), 32'(regv[4][4:0]));
		chk("adc2_gain", 32'(adc2_gain), 32'(adc2_input_b_sel ?
			regv[6][4:0] : regv[5][4:0]));
		chk("adc3_gain", 32'(adc3_gain), 32'(regv[7][4:0]));
		chk("gain_vld", 32'(adc3_gain_vld), 32'(!adc3_input_d_sel));
		chk("adc3_ofs", 32'(adc3_offset), 32'(regv[0][11:0]));
		chk("ofs_vld", 32'(adc3_offset_vld), 32'(adc3_input_d_sel));
		chk("adc4_ofs", 32'(adc4_offset), 32'(regv[1][11:0]));
		chk("adc5_ofs", 32'(adc5_offset), 32'(regv[2][11:0]));
	endtask

	initial begin
		err_count        = 0;
		tests_run        = 0;
		rst_n            = 1'b0;
		avs_address      = 12'h000;
		avs_read         = 1'b0;
		avs_write        = 1'b0;
		avs_writedata    = 32'h0000_0000;
		avs_byteenable   = 4'h0;
		adc2_input_b_sel = 1'b0;
		adc3_input_d_sel = 1'b0;
		do_reset;
		@(posedge clk_sys);
		chk("loading", 32'(trim_ready), 32'h0);
		chk("fuse_req", 32'(fuse_rd_req), 32'h1);
		// First read is raised during the fuse load and must wait it out
		read_all;
		chk("loaded", 32'(trim_ready), 32'h1);
		chk("fuse_done", 32'(fuse_rd_req), 32'h0);
		chk_outs;
		// One write per register with an idle cycle between, reserved bits kept at zero
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, idx[i], {16'h0000, wv[i]}, 4'hF, rd);
			regv[i] = wv[i];
		end
		read_all;
		chk_outs;
		for (int s = 0; s < 4; s++) begin
			adc2_input_b_sel <= s[0];
			adc3_input_d_sel <= s[1];
			repeat (3) @(posedge clk_sys);
			chk_outs;
		end
		// Low byte only, reserved nibble left at zero
		bus(1'b1, idx[1], 32'h0000_0055, 4'h1, rd);
		regv[1][7:0] = 8'h55;
		bus(1'b1, idx[2], 32'h0000_0123, 4'h0, rd);
		bus(1'b1, 10'h365, 32'h0000_001F, 4'hF, rd);
		bus(1'b0, 10'h33B, 32'h0, 4'hF, rd);
		chk("unmapped", rd, 32'h0000_0000);
		read_all;
		chk_outs;
		// Second reset in mid-run reloads the factory values
		do_reset;
		read_all;
		chk_outs;
		end_of_test;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		$display("MISMATCH watchdog expected finish seen hang");
		end_of_test;
	end
endmodule
